// *** hw/dsf_top.sv ***
// Strap loader, output stagger, line fault status and trigger forwarding
//
// What this block does
// - Stagger group delays 0/0.5/1/1.5, clock 0.75 ns
// - Control bit 3 at 0x08 disables staggering
// - Control channel on: GPIO and mode select pins
// - Control channel off: latch double, width, sync straps
// - Strap mode: error correction strap enables correction
// - Strap mode: edge strap picks falling output edge
// - Straps latched once after each reset release only
// - Status bits 3:2 hold negative wire code
// - Status bits 1:0 hold positive wire code
// - Fault pin low during fault, high when normal
// - Trigger input reaches far output within 0.35 ms
`timescale 1ns/1ps
module dsf_top #(
  parameter int TRIG_LIMIT_CYC = dsf_pkg::TRIG_MAX_CYC
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write
  input  wire logic [5:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [5:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Strap and dual-function pins
  input  wire logic                  local_ctrl_chan_enable,
  input  wire logic [4:0]            dual_pins,
  // Configuration results
  output dsf_pkg::dsf_cfg_s          cfg,
  output logic                       ctrl_chan_en,
  output logic [1:0]                 gpio_in,
  output logic                       base_bypass_select,
  output dsf_pkg::dsf_stag_s         stag_dly,
  // Line fault detector
  input  wire logic [1:0]            neg_wire_fault_code,
  input  wire logic [1:0]            pos_wire_fault_code,
  output logic                       line_fault_n,
  // Trigger forwarding
  input  wire logic                  remote_trigger_input,
  output logic                       remote_trigger_output,
  // Interrupt
  output logic                       irq
);
  import dsf_pkg::*;

  localparam logic [TRIG_CNT_W-1:0] TRIG_LOAD =
    TRIG_CNT_W'(TRIG_LIMIT_CYC - TRIG_OVH_CYC);

  typedef struct packed {
    logic [4:0]            pin_s1;
    logic [4:0]            pin_s2;
    logic                  lcc_s1;
    logic                  lcc_s2;
    logic [3:0]            lf_s1;
    logic [3:0]            lf_s2;
    logic                  trig_s1;
    logic                  trig_s2;
    logic                  trig_s3;
    logic [1:0]            boot_cnt;
    dsf_cfg_s              cfg;
    logic [1:0]            gpio;
    logic                  bypass;
    logic [3:0]            fault_code;
    logic                  fault_n;
    logic                  trig_out;
    logic                  trig_pend;
    logic [TRIG_CNT_W-1:0] trig_cnt;
    logic                  stag_dis;
    dsf_stag_s             stag;
    logic [IRQ_W-1:0]      irq_stat;
    logic [IRQ_W-1:0]      irq_en;
    logic                  aw_held;
    logic [5:0]            aw_addr;
    logic                  w_held;
    logic [7:0]            wdata;
    logic                  wstrb0;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
  } dsf_state_s;

  dsf_state_s st_ff;
  dsf_state_s nxt_st;

  // ==========================================================================
  // Helpers
  function automatic logic is_fault(input logic [3:0] code);
    return (code[3:2] != LF_NORMAL) || (code[1:0] != LF_NORMAL);
  endfunction

  function automatic logic is_mapped(input logic [5:0] addr);
    return (addr == OFF_CTRL) || (addr == OFF_LINE_FAULT_N) ||
           (addr == OFF_STRAP) || (addr == OFF_IRQ_STAT) ||
           (addr == OFF_IRQ_CLR) || (addr == OFF_IRQ_EN);
  endfunction

  logic             do_wr;
  logic             ev_fault_set;
  logic             ev_fault_clr;
  logic             ev_trig;
  logic [IRQ_W-1:0] irq_clr;
  logic [31:0]      rd_val;

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    // Synchronisers
    nxt_st.pin_s1  = dual_pins;
    nxt_st.pin_s2  = st_ff.pin_s1;
    nxt_st.lcc_s1  = local_ctrl_chan_enable;
    nxt_st.lcc_s2  = st_ff.lcc_s1;
    nxt_st.lf_s1   = {neg_wire_fault_code, pos_wire_fault_code};
    nxt_st.lf_s2   = st_ff.lf_s1;
    nxt_st.trig_s1 = remote_trigger_input;
    nxt_st.trig_s2 = st_ff.trig_s1;
    nxt_st.trig_s3 = st_ff.trig_s2;

    // Strap capture once the synchronisers have filled
    if (!st_ff.cfg.strap_valid) begin
      if (st_ff.boot_cnt != BOOT_CYC) begin
        nxt_st.boot_cnt = st_ff.boot_cnt + 2'h1;
      end else begin
        nxt_st.cfg.strap_valid = 1'b1;
        nxt_st.cfg.lcc_en      = st_ff.lcc_s2;
        if (!st_ff.lcc_s2) begin
          nxt_st.cfg.double_out    = st_ff.pin_s2[PIN_DBL];
          nxt_st.cfg.bus_32bit     = st_ff.pin_s2[PIN_BWS];
          nxt_st.cfg.sync_encode   = st_ff.pin_s2[PIN_MS];
          nxt_st.cfg.error_correct = st_ff.pin_s2[PIN_EDC];
          nxt_st.cfg.edge_falling  = st_ff.pin_s2[PIN_ES];
        end
      end
    end

    // Live GPIO and mode inputs with the control channel on
    if (st_ff.cfg.strap_valid && st_ff.cfg.lcc_en) begin
      nxt_st.gpio   = st_ff.pin_s2[PIN_BWS:PIN_DBL];
      nxt_st.bypass = st_ff.pin_s2[PIN_MS];
    end else begin
      nxt_st.gpio   = 2'h0;
      nxt_st.bypass = 1'b0;
    end

    // Line fault status and pin
    nxt_st.fault_code = st_ff.lf_s2;
    nxt_st.fault_n    = !is_fault(st_ff.lf_s2);
    ev_fault_set      = st_ff.fault_n && is_fault(st_ff.lf_s2);
    ev_fault_clr      = !st_ff.fault_n && !is_fault(st_ff.lf_s2);

    // Trigger forwarding with a bounded delay
    ev_trig = 1'b0;
    if (st_ff.trig_s2 != st_ff.trig_s3) begin
      nxt_st.trig_pend = 1'b1;
      nxt_st.trig_cnt  = TRIG_LOAD;
    end else if (st_ff.trig_pend) begin
      if (st_ff.trig_cnt == '0) begin
        nxt_st.trig_pend = 1'b0;
        nxt_st.trig_out  = st_ff.trig_s2;
        ev_trig          = 1'b1;
      end else begin
        nxt_st.trig_cnt = st_ff.trig_cnt - TRIG_CNT_W'(1);
      end
    end

    // Stagger delays
    if (st_ff.stag_dis) begin
      nxt_st.stag = '0;
    end else begin
      nxt_st.stag = '{grp0: STAG_G0_PS, grp1: STAG_G1_PS,
                      grp2: STAG_G2_PS, grp3: STAG_G3_PS,
                      pclk: STAG_PCLK_PS};
    end

    // AXI write channel: address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata  = s_axi_wdata[7:0];
      nxt_st.wstrb0 = s_axi_wstrb[0];
    end
    do_wr   = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    irq_clr = '0;
    if (do_wr) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = is_mapped(st_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (st_ff.wstrb0) begin
        unique case (st_ff.aw_addr)
          OFF_CTRL:    nxt_st.stag_dis = st_ff.wdata[CTRL_STAG_DIS_BIT];
          OFF_IRQ_CLR: irq_clr         = st_ff.wdata[IRQ_W-1:0];
          OFF_IRQ_EN:  nxt_st.irq_en   = st_ff.wdata[IRQ_W-1:0];
          default:     ;
        endcase
      end
    end else if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Sticky status, a set in the clearing cycle wins
    nxt_st.irq_stat = (st_ff.irq_stat & ~irq_clr);
    nxt_st.irq_stat[IRQ_FAULT_SET] =
      nxt_st.irq_stat[IRQ_FAULT_SET] | ev_fault_set;
    nxt_st.irq_stat[IRQ_FAULT_CLR] =
      nxt_st.irq_stat[IRQ_FAULT_CLR] | ev_fault_clr;
    nxt_st.irq_stat[IRQ_TRIG] = nxt_st.irq_stat[IRQ_TRIG] | ev_trig;

    // AXI read channel
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFF_CTRL:     rd_val[CTRL_STAG_DIS_BIT] = st_ff.stag_dis;
      OFF_LINE_FAULT_N:     rd_val[3:0]       = st_ff.fault_code;
      OFF_STRAP:    rd_val[6:0]       = st_ff.cfg;
      OFF_IRQ_STAT: rd_val[IRQ_W-1:0] = st_ff.irq_stat;
      OFF_IRQ_EN:   rd_val[IRQ_W-1:0] = st_ff.irq_en;
      default:      ;
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_val;
      nxt_st.rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end

    if (!aresetn) begin
      nxt_st            = '0;
      // Fault synchronisers idle at the normal code, no false edge
      nxt_st.lf_s1      = LF_RST;
      nxt_st.lf_s2      = LF_RST;
      nxt_st.fault_code = LF_RST;
      nxt_st.fault_n    = 1'b1;
      nxt_st.stag_dis   = STAG_DIS_RST;
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  // ==========================================================================
  // Outputs
  assign s_axi_awready        = !st_ff.aw_held && !st_ff.bvalid;
  assign s_axi_wready         = !st_ff.w_held && !st_ff.bvalid;
  assign s_axi_bvalid         = st_ff.bvalid;
  assign s_axi_bresp          = st_ff.bresp;
  assign s_axi_arready        = !st_ff.rvalid;
  assign s_axi_rvalid         = st_ff.rvalid;
  assign s_axi_rdata          = st_ff.rdata;
  assign s_axi_rresp          = st_ff.rresp;
  assign cfg                  = st_ff.cfg;
  assign ctrl_chan_en         = st_ff.cfg.strap_valid && st_ff.cfg.lcc_en;
  assign gpio_in              = st_ff.gpio;
  assign base_bypass_select   = st_ff.bypass;
  assign stag_dly             = st_ff.stag;
  assign line_fault_n         = st_ff.fault_n;
  assign remote_trigger_output = st_ff.trig_out;
  assign irq                  = |(st_ff.irq_stat & st_ff.irq_en);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [TRIG_CNT_W-1:0] lag_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || (st_ff.trig_s2 == st_ff.trig_out)) begin
      lag_cnt <= '0;
    end else begin
      lag_cnt <= lag_cnt + TRIG_CNT_W'(1);
    end
  end

  property p_stag_on;
    aresetn && !st_ff.stag_dis ##1 !st_ff.stag_dis |->
      stag_dly.grp1 == STAG_G1_PS && stag_dly.grp3 == STAG_G3_PS &&
      stag_dly.pclk == STAG_PCLK_PS;
  endproperty
  a_stag_on: assert property (p_stag_on) else $error("stagger wrong");

  sequence s_ctrl_wr;
    do_wr && st_ff.wstrb0 && st_ff.aw_addr == OFF_CTRL;
  endsequence
  property p_ctrl_wr;
    s_ctrl_wr |=> st_ff.stag_dis == $past(st_ff.wdata[CTRL_STAG_DIS_BIT])
      ##1 (st_ff.stag_dis ? stag_dly == '0 : stag_dly.grp2 == STAG_G2_PS);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("ctrl bit lost");

  property p_lcc_gpio;
    ctrl_chan_en ##1 ctrl_chan_en |-> gpio_in == $past(st_ff.pin_s2[1:0]);
  endproperty
  a_lcc_gpio: assert property (p_lcc_gpio) else $error("gpio wrong");

  property p_strap_cap;
    $rose(cfg.strap_valid) && !cfg.lcc_en |->
      cfg.double_out == $past(st_ff.pin_s2[PIN_DBL]) &&
      cfg.bus_32bit == $past(st_ff.pin_s2[PIN_BWS]) &&
      cfg.sync_encode == $past(st_ff.pin_s2[PIN_MS]);
  endproperty
  a_strap_cap: assert property (p_strap_cap) else $error("strap bad");

  property p_ecc_edge;
    $rose(cfg.strap_valid) && !cfg.lcc_en |->
      cfg.error_correct == $past(st_ff.pin_s2[PIN_EDC]) &&
      cfg.edge_falling == $past(st_ff.pin_s2[PIN_ES]);
  endproperty
  a_ecc_edge: assert property (p_ecc_edge) else $error("ecc/edge bad");

  property p_strap_hold;
    cfg.strap_valid |=> $stable(cfg);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap moved");

  property p_line_fault_n_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_LINE_FAULT_N |=>
      s_axi_rvalid && s_axi_rdata[3:0] == $past(st_ff.fault_code);
  endproperty
  a_line_fault_n_read: assert property (p_line_fault_n_read) else $error("lf read");

  property p_fault_pin;
    ##1 line_fault_n == !is_fault($past(st_ff.lf_s2));
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin");

  property p_fault_follow;
    (aresetn &&
     $stable({neg_wire_fault_code, pos_wire_fault_code})) [*4] |->
      line_fault_n == !is_fault({neg_wire_fault_code, pos_wire_fault_code});
  endproperty
  a_fault_follow: assert property (p_fault_follow) else $error("pin lag");

  property p_trig_bound;
    lag_cnt <= TRIG_CNT_W'(TRIG_LIMIT_CYC);
  endproperty
  a_trig_bound: assert property (p_trig_bound) else $error("trig slow");

endmodule // dsf_top

// *** common/dsf_pkg.sv ***
// Constants, field layouts and carrier types of the strap and fault block
package dsf_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam int          ADDR_W       = 6;
  localparam logic [5:0]  OFF_CTRL     = 6'h08;
  localparam logic [5:0]  OFF_LINE_FAULT_N     = 6'h14;
  localparam logic [5:0]  OFF_STRAP    = 6'h20;
  localparam logic [5:0]  OFF_IRQ_STAT = 6'h24;
  localparam logic [5:0]  OFF_IRQ_CLR  = 6'h28;
  localparam logic [5:0]  OFF_IRQ_EN   = 6'h2C;

  // ==========================================================================
  // Fields and reset values
  localparam int          CTRL_STAG_DIS_BIT = 3;
  localparam logic        STAG_DIS_RST      = 1'h0;
  localparam logic [1:0]  LF_NORMAL         = 2'h2;
  localparam logic [3:0]  LF_RST            = 4'hA;
  localparam int          IRQ_W             = 3;
  localparam int          IRQ_FAULT_SET     = 0;
  localparam int          IRQ_FAULT_CLR     = 1;
  localparam int          IRQ_TRIG          = 2;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // Dual-function pin positions
  localparam int PIN_DBL = 0;
  localparam int PIN_BWS = 1;
  localparam int PIN_MS  = 2;
  localparam int PIN_EDC = 3;
  localparam int PIN_ES  = 4;
  localparam int PIN_N   = 5;

  // ==========================================================================
  // Stagger delays in picoseconds
  localparam logic [10:0] STAG_G0_PS   = 11'h000;
  localparam logic [10:0] STAG_G1_PS   = 11'h1F4;
  localparam logic [10:0] STAG_G2_PS   = 11'h3E8;
  localparam logic [10:0] STAG_G3_PS   = 11'h5DC;
  localparam logic [10:0] STAG_PCLK_PS = 11'h2EE;

  // ==========================================================================
  // Timing
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          TRIG_MAX_NS   = 350000;
  localparam int          TRIG_MAX_CYC  = TRIG_MAX_NS / CLK_PERIOD_NS;
  localparam int          TRIG_OVH_CYC  = 4;
  localparam int          TRIG_CNT_W    = 13;
  localparam logic [1:0]  BOOT_CYC      = 2'h3;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic strap_valid;
    logic lcc_en;
    logic double_out;
    logic bus_32bit;
    logic sync_encode;
    logic error_correct;
    logic edge_falling;
  } dsf_cfg_s;

  typedef struct packed {
    logic [10:0] grp0;
    logic [10:0] grp1;
    logic [10:0] grp2;
    logic [10:0] grp3;
    logic [10:0] pclk;
  } dsf_stag_s;

endpackage

// *** verification/dsf_host_model.sv ***
// Host controller and strap wiring model on the far side of the block
`timescale 1ns/1ps
module dsf_host_model #(
  parameter int SPACE_CYC = 20,
  parameter int FILT_CYC  = 4
) (
  // Clock
  input  wire logic  aclk,
  // Pins of the block
  input  wire logic  line_fault_n,
  output logic       local_ctrl_chan_enable,
  output logic [4:0] dual_pins,
  output logic       remote_trigger_input,
  // Filtered fault view
  output logic       fault_seen
);
  int low_cnt;
  int cyc;
  int last_cyc;

  initial begin
    local_ctrl_chan_enable = 1'b0;
    dual_pins = 5'h00;
    remote_trigger_input = 1'b0;
    fault_seen = 1'b0;
    low_cnt = 0;
    cyc = 0;
    last_cyc = -SPACE_CYC;
  end

  // ====================
  // Fault pin filter against short ground shifts
  always @(posedge aclk) begin
    low_cnt <= line_fault_n ? 0 : low_cnt + 1;
    fault_seen <= !line_fault_n && (low_cnt >= FILT_CYC - 1);
    cyc <= cyc + 1;
  end

  // ====================
  // Strap wiring and trigger source
  task automatic set_straps(input logic lcc, input logic [4:0] pins);
    local_ctrl_chan_enable <= lcc;
    dual_pins <= pins;
  endtask

  task automatic set_trig(input logic v);
    while (cyc - last_cyc < SPACE_CYC) @(posedge aclk);
    @(posedge aclk);
    remote_trigger_input <= v;
    last_cyc = cyc;
  endtask
endmodule // dsf_host_model

// *** verification/tb.sv ***
// Self-checking testbench of the strap, stagger and line fault block
`timescale 1ns/1ps
module tb;
  import dsf_pkg::*;
  localparam int TLIM = 20;
  localparam logic [54:0] STAG_ON =
    {11'h000, 11'h1F4, 11'h3E8, 11'h5DC, 11'h2EE};

  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] neg_code, pos_code;
  logic awready, wready, bvalid, arready, rvalid, lfn, trig_out, irq;
  logic lcc, trig_in, ctrl_en, bbs, fseen;
  logic [1:0] bresp, rresp, gpio;
  logic [4:0] pins;
  logic [3:0] wstrb;
  dsf_cfg_s cfg;
  dsf_stag_s stag;
  int err_total, checks;

  dsf_top #(.TRIG_LIMIT_CYC(TLIM)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .local_ctrl_chan_enable(lcc), .dual_pins(pins), .cfg(cfg),
    .ctrl_chan_en(ctrl_en), .gpio_in(gpio), .base_bypass_select(bbs),
    .stag_dly(stag), .neg_wire_fault_code(neg_code),
    .pos_wire_fault_code(pos_code), .line_fault_n(lfn),
    .remote_trigger_input(trig_in), .remote_trigger_output(trig_out),
    .irq(irq));

  dsf_host_model #(.SPACE_CYC(TLIM)) host (
    .aclk(aclk), .line_fault_n(lfn), .local_ctrl_chan_enable(lcc),
    .dual_pins(pins), .remote_trigger_input(trig_in), .fault_seen(fseen));

  // ====================
  // Clock, checks and bus cycles
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {bvalid, bresp}, {1'b1, er});
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rresp", {rvalid, rresp}, {1'b1, er});
    if (er == RESP_OKAY) chk("rdata", rdata, ed);
  endtask

  task automatic pwr(input logic l, input logic [4:0] p);
    @(posedge aclk);
    aresetn <= 1'b0;
    host.set_straps(l, p);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
  endtask

  // ====================
  // Scenarios
  task automatic t_straps();
    logic [4:0] pat [2];
    logic [6:0] e;
    pat[0] = 5'h15;
    pat[1] = 5'h0A;
    foreach (pat[i]) begin
      pwr(1'b0, pat[i]);
      e = {2'b10, pat[i][0], pat[i][1], pat[i][2], pat[i][3], pat[i][4]};
      chk("cfg", cfg, e);
      chk("ctrl_en", {ctrl_en, gpio, bbs}, 4'h0);
      rdc(OFF_STRAP, {25'h0, e}, RESP_OKAY);
      host.set_straps(1'b1, ~pat[i]);
      repeat (8) @(negedge aclk);
      chk("cfg_held", cfg, e);
    end
  endtask

  task automatic t_regs_stag();
    chk("lfn_after_reset", lfn, 1'b1);
    rdc(OFF_IRQ_STAT, 32'h0000_0000, RESP_OKAY);
    rdc(OFF_LINE_FAULT_N, 32'h0000_000A, RESP_OKAY);
    rdc(OFF_IRQ_EN, 32'h0000_0000, RESP_OKAY);
    rdc(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    chk("stag_on", stag, STAG_ON);
    wr(OFF_CTRL, 32'h0000_0008, RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk("stag_off", stag, 55'h0);
    rdc(OFF_CTRL, 32'h0000_0008, RESP_OKAY);
    wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    repeat (2) @(negedge aclk);
    chk("stag_back", stag, STAG_ON);
    @(posedge aclk);
    wstrb <= 4'hE;
    wr(OFF_CTRL, 32'h0000_0008, RESP_OKAY);
    wstrb <= 4'hF;
    rdc(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    wr(6'h3C, 32'h0000_0001, RESP_SLVERR);
    rdc(6'h3C, 32'h0000_0000, RESP_SLVERR);
    wr(OFF_LINE_FAULT_N, 32'h0000_0000, RESP_OKAY);
    rdc(OFF_LINE_FAULT_N, 32'h0000_000A, RESP_OKAY);
  endtask

  task automatic t_fault();
    wr(OFF_IRQ_EN, 32'h0000_0001, RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      @(posedge aclk);
      neg_code <= i[3:2];
      pos_code <= i[1:0];
      repeat (4) @(negedge aclk);
      chk("line_fault_n", lfn, i == 10);
      rdc(OFF_LINE_FAULT_N, i, RESP_OKAY);
    end
    repeat (4) @(negedge aclk);
    chk("irq_fault", {irq, fseen}, 2'h3);
    wr(OFF_IRQ_EN, 32'h0000_0000, RESP_OKAY);
    @(negedge aclk);
    chk("irq_masked", irq, 1'b0);
    wr(OFF_IRQ_CLR, 32'h0000_0007, RESP_OKAY);
    wr(OFF_IRQ_EN, 32'h0000_0003, RESP_OKAY);
    @(negedge aclk);
    chk("irq_cleared", irq, 1'b0);
    @(posedge aclk);
    neg_code <= LF_NORMAL;
    pos_code <= LF_NORMAL;
    repeat (4) @(negedge aclk);
    chk("normal", {irq, lfn}, 2'h3);
    rdc(OFF_IRQ_STAT, 32'h0000_0002, RESP_OKAY);
    wr(OFF_IRQ_CLR, 32'h0000_0002, RESP_OKAY);
    @(negedge aclk);
    chk("irq_idle", irq, 1'b0);
    rdc(OFF_IRQ_CLR, 32'h0000_0000, RESP_OKAY);
  endtask

  task automatic t_trig();
    int n;
    for (int v = 1; v >= 0; v--) begin
      host.set_trig(v[0]);
      n = 0;
      @(negedge aclk);
      while (trig_out !== v[0] && n < TLIM + 5) begin
        @(negedge aclk);
        n++;
      end
      chk("trig_lat", n <= TLIM && trig_out === v[0], 1'b1);
    end
    rdc(OFF_IRQ_STAT, 32'h0000_0004, RESP_OKAY);
  endtask

  task automatic t_lcc();
    pwr(1'b1, 5'h07);
    chk("lcc_cfg", {ctrl_en, cfg}, 8'hE0);
    chk("gpio_ms", {gpio, bbs}, 3'h7);
    @(posedge aclk);
    host.set_straps(1'b1, 5'h02);
    repeat (4) @(negedge aclk);
    chk("gpio_live", {gpio, bbs}, 3'h4);
  endtask

  // ====================
  // Main sequence and watchdog
  initial begin
    err_total = 0;
    checks = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 6'h00;
    araddr = 6'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    neg_code = LF_NORMAL;
    pos_code = LF_NORMAL;
    t_straps();
    t_regs_stag();
    t_fault();
    t_trig();
    t_lcc();
    results();
  end

  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    results();
  end
endmodule // tb
